// ==== hw/cpu_arithmetic_unit.sv ====
// Arithmetic execution unit with an AHB-Lite register front end
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
module cpu_arithmetic_unit (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	function automatic logic [4:0] shift_of(input alu_pkg::size_t sz);
		return (sz == alu_pkg::sz_byte) ? alu_pkg::SH_BYTE :
		       (sz == alu_pkg::sz_word) ? alu_pkg::SH_WORD : 5'h0;
	endfunction : shift_of

	// Negative and zero of a value taken at the given size
	function automatic logic [1:0] nz(input logic [31:0] x, input alu_pkg::size_t sz);
		logic [31:0] v;
		v = x << shift_of(sz);
		return {v[31], (v == 32'h0)};
	endfunction : nz

	// Operands are aligned to bit 31 so one adder yields carry and overflow at every size
	function automatic alu_pkg::arith_t arith(input logic [31:0] a, input logic [31:0] b,
		input logic [31:0] base, input logic ci, input logic sub, input alu_pkg::size_t sz);
		logic [4:0]     sh;
		logic [31:0]    as;
		logic [31:0]    bs;
		logic [31:0]    lo;
		logic [31:0]    mask;
		logic [32:0]    s;
		alu_pkg::arith_t o;
		sh   = shift_of(sz);
		as   = a << sh;
		bs   = (sub ? ~b : b) << sh;
		s    = {1'b0, as} + {1'b0, bs} + ({32'h0, ci} << sh);
		mask = {32{1'b1}} >> sh;
		lo   = s[31:0] >> sh;
		o.r   = (base & ~mask) | lo;
		o.f.n = s[31];
		o.f.z = (lo == 32'h0);
		o.f.v = (as[31] == bs[31]) && (s[31] != as[31]);
		o.f.c = s[32] ^ sub;
		return o;
	endfunction : arith

	function automatic logic [15:0] neg16(input logic [15:0] x, input logic s);
		return s ? 16'h0 - x : x;
	endfunction : neg16

	alu_pkg::ctrl_t  ctrl_q;
	alu_pkg::flags_t flags_q;
	alu_pkg::flags_t flg_d;
	alu_pkg::state_t st_q;
	alu_pkg::state_t st_d;
	alu_pkg::size_t  sz;
	alu_pkg::arith_t add_r;
	alu_pkg::arith_t sub_r;
	alu_pkg::arith_t add_with_carry_r;
	alu_pkg::arith_t subtract_with_carry_r;
	alu_pkg::arith_t inc_r;
	alu_pkg::arith_t dec_r;
	alu_pkg::arith_t neg_r;
	logic [31:0] dst_q;
	logic [31:0] src_q;
	logic [31:0] result_q;
	logic [31:0] res_d;
	logic [31:0] hrdata_q;
	logic [31:0] rd_word;
	logic [31:0] step_v;
	logic [31:0] inc_v;
	logic [31:0] prod;
	logic [31:0] prod_res;
	logic [31:0] dv_dividend;
	logic [31:0] dv_quo;
	logic [31:0] div_res;
	logic [31:0] zext_v;
	logic [15:0] dv_divisor;
	logic [15:0] dv_rem;
	logic [15:0] q_signed;
	logic [15:0] r_signed;
	logic [7:0]  addr_q;
	logic [7:0]  bcd_in;
	logic [7:0]  daa_adj;
	logic [7:0]  das_adj;
	logic [7:0]  daa_b;
	logic [7:0]  das_b;
	logic [1:0]  nz_prod;
	logic [1:0]  nz_bcd_a;
	logic [1:0]  nz_bcd_s;
	logic [1:0]  nz_zext;
	logic        hreadyout_q;
	logic        hresp_q;
	logic        rd_pend_q;
	logic        wr_pend_q;
	logic        go_q;
	logic        busy;
	logic        addr_ph;
	logic        wr_ok;
	logic        wr_dst;
	logic        wr_src;
	logic        wr_ctrl;
	logic        wr_flags;
	logic        byte_form;
	logic        is_div;
	logic        is_sdiv;
	logic        dvd_neg;
	logic        dvs_neg;
	logic        dv_start;
	logic        dv_done;
	logic        lo_over;
	logic        hi_over;

	// Bus front end: writes complete with no wait, reads insert one wait state
	assign addr_ph  = hsel & htrans[1] & hready;
	assign busy     = go_q | (st_q == alu_pkg::st_div);
	assign wr_ok    = wr_pend_q & ~busy;
	assign wr_dst   = wr_ok & (addr_q == alu_pkg::ADDR_DST);
	assign wr_src   = wr_ok & (addr_q == alu_pkg::ADDR_SRC);
	assign wr_ctrl  = wr_ok & (addr_q == alu_pkg::ADDR_CTRL);
	assign wr_flags = wr_ok & (addr_q == alu_pkg::ADDR_FLAGS);

	assign rd_word = (addr_q == alu_pkg::ADDR_DST)    ? dst_q :
	                 (addr_q == alu_pkg::ADDR_SRC)    ? src_q :
	                 (addr_q == alu_pkg::ADDR_CTRL)   ? {23'h0, ctrl_q} :
	                 (addr_q == alu_pkg::ADDR_RESULT) ? result_q :
	                 (addr_q == alu_pkg::ADDR_FLAGS)  ? {28'h0, flags_q} :
	                 (addr_q == alu_pkg::ADDR_STATUS) ? {31'h0, busy} : 32'h0;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			addr_q      <= 8'h0;
			wr_pend_q   <= 1'b0;
			rd_pend_q   <= 1'b0;
			hreadyout_q <= 1'b1;
			hrdata_q    <= alu_pkg::WORD_RST;
			hresp_q     <= 1'b0;
		end else begin
			wr_pend_q <= addr_ph & hwrite & (hsize == alu_pkg::HSIZE_WORD);
			if (addr_ph) begin
				addr_q      <= haddr[7:0];
				rd_pend_q   <= ~hwrite;
				hreadyout_q <= hwrite;
			end else if (rd_pend_q) begin
				hrdata_q    <= rd_word;
				rd_pend_q   <= 1'b0;
				hreadyout_q <= 1'b1;
			end
		end
	end

	assign hreadyout = hreadyout_q;
	assign hrdata    = hrdata_q;
	assign hresp     = hresp_q;

	// Operand registers; frozen while an operation is in flight
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dst_q  <= alu_pkg::WORD_RST;
			src_q  <= alu_pkg::WORD_RST;
			ctrl_q <= alu_pkg::ctrl_t'(alu_pkg::CTRL_RST);
			go_q   <= 1'b0;
		end else begin
			go_q <= wr_ctrl;
			if (wr_dst)
				dst_q <= hwdata;
			if (wr_src)
				src_q <= hwdata;
			if (wr_ctrl)
				ctrl_q <= alu_pkg::ctrl_t'(hwdata[alu_pkg::CTRL_W-1:0]);
		end
	end

	assign sz        = ctrl_q.size;
	assign byte_form = (sz == alu_pkg::sz_byte);
	assign is_sdiv   = (ctrl_q.op == alu_pkg::signed_divide);
	assign is_div    = is_sdiv | (ctrl_q.op == alu_pkg::unsigned_divide);

	assign step_v = (ctrl_q.step == alu_pkg::STEP_CODE4) ? alu_pkg::STEP4 :
	                (ctrl_q.step == alu_pkg::STEP_CODE2) ? alu_pkg::STEP2 : alu_pkg::STEP1;
	// A step of two is not offered on bytes, so byte steps fall back to one
	assign inc_v  = (!byte_form && ctrl_q.step != alu_pkg::STEP_CODE1) ? alu_pkg::STEP2 : alu_pkg::STEP1;

	assign add_r  = arith(dst_q, src_q, dst_q, 1'b0, 1'b0, sz);
	assign sub_r  = arith(dst_q, src_q, dst_q, 1'b1, 1'b1, sz);
	assign add_with_carry_r = arith(dst_q, src_q, dst_q, flags_q.c, 1'b0, alu_pkg::sz_byte);
	assign subtract_with_carry_r = arith(dst_q, src_q, dst_q, ~flags_q.c, 1'b1, alu_pkg::sz_byte);
	assign inc_r  = arith(dst_q, inc_v, dst_q, 1'b0, 1'b0, sz);
	assign dec_r  = arith(dst_q, inc_v, dst_q, 1'b1, 1'b1, sz);
	assign neg_r  = arith(32'h0, dst_q, dst_q, 1'b1, 1'b1, sz);

	assign bcd_in   = dst_q[7:0];
	assign lo_over  = (bcd_in[3:0] > alu_pkg::BCD_NIB_MAX);
	assign hi_over  = flags_q.c | (bcd_in > alu_pkg::BCD_BYTE_MAX);
	assign daa_adj  = (hi_over ? alu_pkg::BCD_HI_ADJ : 8'h0) | (lo_over ? alu_pkg::BCD_LO_ADJ : 8'h0);
	assign das_adj  = (flags_q.c ? alu_pkg::BCD_HI_ADJ : 8'h0) | (lo_over ? alu_pkg::BCD_LO_ADJ : 8'h0);
	assign daa_b    = bcd_in + daa_adj;
	assign das_b    = bcd_in - das_adj;
	assign nz_bcd_a = nz({24'h0, daa_b}, alu_pkg::sz_byte);
	assign nz_bcd_s = nz({24'h0, das_b}, alu_pkg::sz_byte);

	mul_unit u_mul (
		.a         (dst_q[15:0]),
		.b         (src_q[15:0]),
		.is_signed (ctrl_q.op == alu_pkg::signed_multiply),
		.size      (sz),
		.product   (prod)
	);

	assign prod_res = byte_form ? {dst_q[31:16], prod[15:0]} : prod;
	assign nz_prod  = nz(prod, byte_form ? alu_pkg::sz_word : alu_pkg::sz_long);

	// Divider works on magnitudes; signs are restored on the way out
	assign dvd_neg     = is_sdiv & (byte_form ? dst_q[15] : dst_q[31]);
	assign dvs_neg     = is_sdiv & (byte_form ? src_q[7] : src_q[15]);
	assign dv_dividend = byte_form ? {16'h0, neg16(dst_q[15:0], dvd_neg)} :
	                     (dvd_neg ? 32'h0 - dst_q : dst_q);
	assign dv_divisor  = neg16(byte_form ? {{8{dvs_neg}}, src_q[7:0]} : src_q[15:0], dvs_neg);
	assign dv_start    = go_q & is_div;

	div_unit u_div (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.start     (dv_start),
		.dividend  (dv_dividend),
		.divisor   (dv_divisor),
		.done      (dv_done),
		.quotient  (dv_quo),
		.remainder (dv_rem)
	);

	assign q_signed = neg16(dv_quo[15:0], dvd_neg ^ dvs_neg);
	assign r_signed = neg16(dv_rem, dvd_neg);
	assign div_res  = byte_form ? {dst_q[31:16], r_signed[7:0], q_signed[7:0]} : {r_signed, q_signed};

	assign zext_v  = (sz == alu_pkg::sz_long) ? {16'h0, dst_q[15:0]} : {dst_q[31:16], 8'h0, dst_q[7:0]};
	assign nz_zext = nz(zext_v, sz);

	always_comb begin
		res_d = dst_q;
		flg_d = flags_q;
		unique case (ctrl_q.op)
			alu_pkg::op_add: begin
				res_d = add_r.r;
				flg_d = add_r.f;
			end
			alu_pkg::op_sub: begin
				res_d = sub_r.r;
				flg_d = sub_r.f;
			end
			alu_pkg::add_with_carry: begin
				// Zero only stays set so multi-byte chains test the whole value
				res_d = add_with_carry_r.r;
				flg_d = {add_with_carry_r.f.n, add_with_carry_r.f.z & flags_q.z, add_with_carry_r.f.v, add_with_carry_r.f.c};
			end
			alu_pkg::subtract_with_carry: begin
				res_d = subtract_with_carry_r.r;
				flg_d = {subtract_with_carry_r.f.n, subtract_with_carry_r.f.z & flags_q.z, subtract_with_carry_r.f.v, subtract_with_carry_r.f.c};
			end
			alu_pkg::op_increment: begin
				res_d = inc_r.r;
				flg_d = {inc_r.f.n, inc_r.f.z, inc_r.f.v, flags_q.c};
			end
			alu_pkg::decrement_op: begin
				res_d = dec_r.r;
				flg_d = {dec_r.f.n, dec_r.f.z, dec_r.f.v, flags_q.c};
			end
			alu_pkg::step_add:
				res_d = dst_q + step_v;
			alu_pkg::step_subtract:
				res_d = dst_q - step_v;
			alu_pkg::decimal_adjust_add: begin
				res_d = {dst_q[31:8], daa_b};
				flg_d = {nz_bcd_a, flags_q.v, hi_over};
			end
			alu_pkg::decimal_adjust_sub: begin
				res_d = {dst_q[31:8], das_b};
				flg_d = {nz_bcd_s, flags_q.v, flags_q.c};
			end
			alu_pkg::unsigned_multiply:
				res_d = prod_res;
			alu_pkg::signed_multiply: begin
				res_d = prod_res;
				flg_d = {nz_prod, flags_q.v, flags_q.c};
			end
			alu_pkg::compare_op:
				flg_d = sub_r.f;
			alu_pkg::negate_op: begin
				res_d = neg_r.r;
				flg_d = neg_r.f;
			end
			alu_pkg::zero_extend: begin
				res_d = zext_v;
				flg_d = {1'b0, nz_zext[0], 1'b0, flags_q.c};
			end
			alu_pkg::sign_extend: begin
				res_d = (sz == alu_pkg::sz_long) ? {{16{dst_q[15]}}, dst_q[15:0]} :
				        {dst_q[31:16], {8{dst_q[7]}}, dst_q[7:0]};
				flg_d = {nz(res_d, sz), 1'b0, flags_q.c};
			end
			alu_pkg::test_and_set: begin
				res_d = {dst_q[31:8], dst_q[7:0] | alu_pkg::TAS_MARK};
				flg_d = {nz(dst_q, alu_pkg::sz_byte), 1'b0, flags_q.c};
			end
			default: begin
				res_d = dst_q;
				flg_d = flags_q;
			end
		endcase
	end

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			alu_pkg::st_idle:
				if (dv_start)
					st_d = alu_pkg::st_div;
			alu_pkg::st_div:
				if (dv_done)
					st_d = alu_pkg::st_idle;
		endcase
	end

	// Flags and result; software writes cannot collide since they are held off while busy
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_q     <= alu_pkg::st_idle;
			result_q <= alu_pkg::WORD_RST;
			flags_q  <= alu_pkg::flags_t'(alu_pkg::FLAGS_RST);
		end else begin
			st_q <= st_d;
			if (go_q && !is_div) begin
				result_q <= res_d;
				flags_q  <= flg_d;
			end else if (st_q == alu_pkg::st_div && dv_done) begin
				result_q <= div_res;
				flags_q  <= {byte_form ? q_signed[7] : q_signed[15], dv_divisor == 16'h0, flags_q.v, flags_q.c};
			end else if (wr_flags) begin
				flags_q <= alu_pkg::flags_t'(hwdata[alu_pkg::FLAGS_W-1:0]);
			end
		end
	end

	property p_add_long;
		(go_q && ctrl_q.op == alu_pkg::op_add && sz == alu_pkg::sz_long) |=>
			(result_q == $past(dst_q) + $past(src_q));
	endproperty
	a_add_long: assert property (p_add_long) else $error("longword add result wrong");

	property p_add_with_carry_byte;
		(go_q && ctrl_q.op == alu_pkg::add_with_carry) |=>
			(result_q[7:0] == 8'($past(dst_q[7:0]) + $past(src_q[7:0]) + {7'h0, $past(flags_q.c)}))
			&& (result_q[31:8] == $past(dst_q[31:8]));
	endproperty
	a_add_with_carry_byte: assert property (p_add_with_carry_byte) else $error("carry add byte result wrong");

	property p_inc_byte;
		(go_q && ctrl_q.op == alu_pkg::op_increment && byte_form) |=>
			(result_q[7:0] == 8'($past(dst_q[7:0]) + 8'h1));
	endproperty
	a_inc_byte: assert property (p_inc_byte) else $error("byte increment not by one");

	property p_step_four;
		(go_q && ctrl_q.op == alu_pkg::step_add && ctrl_q.step == alu_pkg::STEP_CODE4) |=>
			(result_q == $past(dst_q) + alu_pkg::STEP4);
	endproperty
	a_step_four: assert property (p_step_four) else $error("step add of four wrong");

	property p_mulu_word;
		(go_q && ctrl_q.op == alu_pkg::unsigned_multiply && sz == alu_pkg::sz_word) |=>
			(result_q == 32'($past(dst_q[15:0]) * $past(src_q[15:0])));
	endproperty
	a_mulu_word: assert property (p_mulu_word) else $error("unsigned word product wrong");

	property p_cmp_keep;
		(go_q && ctrl_q.op == alu_pkg::compare_op && sz == alu_pkg::sz_long) |=>
			(result_q == $past(dst_q)) && (flags_q.z == ($past(dst_q) == $past(src_q)));
	endproperty
	a_cmp_keep: assert property (p_cmp_keep) else $error("compare altered result or zero flag wrong");

	property p_neg_long;
		(go_q && ctrl_q.op == alu_pkg::negate_op && sz == alu_pkg::sz_long) |=>
			(result_q + $past(dst_q) == 32'h0);
	endproperty
	a_neg_long: assert property (p_neg_long) else $error("negate result is not the complement");

	property p_zext_long;
		(go_q && ctrl_q.op == alu_pkg::zero_extend && sz == alu_pkg::sz_long) |=>
			(result_q[31:16] == 16'h0) && (result_q[15:0] == $past(dst_q[15:0]));
	endproperty
	a_zext_long: assert property (p_zext_long) else $error("zero extension wrong");

	property p_sext_word;
		(go_q && ctrl_q.op == alu_pkg::sign_extend && sz == alu_pkg::sz_word) |=>
			(result_q[15:8] == {8{$past(dst_q[7])}}) && (flags_q.n == $past(dst_q[7]));
	endproperty
	a_sext_word: assert property (p_sext_word) else $error("sign extension wrong");

	property p_tas;
		(go_q && ctrl_q.op == alu_pkg::test_and_set) |=>
			result_q[7] && (flags_q.z == ($past(dst_q[7:0]) == 8'h0)) && (flags_q.n == $past(dst_q[7]));
	endproperty
	a_tas: assert property (p_tas) else $error("test-and-set byte or flags wrong");

	property p_div_layout;
		(st_q == alu_pkg::st_div && dv_done && !is_sdiv && sz == alu_pkg::sz_word) |=>
			(result_q == {$past(dv_rem), $past(dv_quo[15:0])});
	endproperty
	a_div_layout: assert property (p_div_layout) else $error("divide halves misplaced");

endmodule : cpu_arithmetic_unit

// ==== hw/alu_pkg.sv ====
// Shared types, register map and constants of the arithmetic execution unit
package alu_pkg;

	typedef enum logic [4:0] {
		op_add              = 5'h00,
		op_sub              = 5'h01,
		add_with_carry      = 5'h02,
		subtract_with_carry = 5'h03,
		op_increment        = 5'h04,
		decrement_op        = 5'h05,
		step_add            = 5'h06,
		step_subtract       = 5'h07,
		decimal_adjust_add  = 5'h08,
		decimal_adjust_sub  = 5'h09,
		unsigned_multiply   = 5'h0a,
		signed_multiply     = 5'h0b,
		unsigned_divide     = 5'h0c,
		signed_divide       = 5'h0d,
		compare_op          = 5'h0e,
		negate_op           = 5'h0f,
		zero_extend         = 5'h10,
		sign_extend         = 5'h11,
		test_and_set        = 5'h12
	} op_t;

	typedef enum logic [1:0] {
		sz_byte = 2'h0,
		sz_word = 2'h1,
		sz_long = 2'h2
	} size_t;

	typedef enum logic [1:0] {
		st_idle = 2'b01,
		st_div  = 2'b10
	} state_t;

	// Control word: op in [4:0], size in [6:5], step code in [8:7]
	typedef struct packed {
		logic [1:0] step;
		size_t      size;
		op_t        op;
	} ctrl_t;

	typedef struct packed {
		logic n;
		logic z;
		logic v;
		logic c;
	} flags_t;

	typedef struct packed {
		flags_t      f;
		logic [31:0] r;
	} arith_t;

	localparam int          CTRL_W       = 9;
	localparam int          FLAGS_W      = 4;
	localparam logic [7:0]  ADDR_DST     = 8'h00;
	localparam logic [7:0]  ADDR_SRC     = 8'h04;
	localparam logic [7:0]  ADDR_CTRL    = 8'h08;
	localparam logic [7:0]  ADDR_RESULT  = 8'h0c;
	localparam logic [7:0]  ADDR_FLAGS   = 8'h10;
	localparam logic [7:0]  ADDR_STATUS  = 8'h14;
	localparam logic [31:0] WORD_RST     = 32'h0;
	localparam logic [3:0]  FLAGS_RST    = 4'h0;
	localparam logic [8:0]  CTRL_RST     = 9'h0;
	localparam logic [2:0]  HSIZE_WORD   = 3'h2;
	localparam logic [1:0]  STEP_CODE1   = 2'h0;
	localparam logic [1:0]  STEP_CODE2   = 2'h1;
	localparam logic [1:0]  STEP_CODE4   = 2'h2;
	localparam logic [31:0] STEP1        = 32'h1;
	localparam logic [31:0] STEP2        = 32'h2;
	localparam logic [31:0] STEP4        = 32'h4;
	localparam logic [4:0]  SH_BYTE      = 5'h18;
	localparam logic [4:0]  SH_WORD      = 5'h10;
	localparam logic [3:0]  BCD_NIB_MAX  = 4'h9;
	localparam logic [7:0]  BCD_BYTE_MAX = 8'h99;
	localparam logic [7:0]  BCD_LO_ADJ   = 8'h06;
	localparam logic [7:0]  BCD_HI_ADJ   = 8'h60;
	localparam logic [7:0]  TAS_MARK     = 8'h80;
	localparam logic [5:0]  DIV_STEPS    = 6'h20;

endpackage : alu_pkg

// ==== hw/mul_unit.sv ====
// Combinational 8x8 or 16x16 multiplier, signed or unsigned
`timescale 1ns/1ns
module mul_unit (
	input  wire logic [15:0]   a,
	input  wire logic [15:0]   b,
	input  wire logic          is_signed,
	input  wire alu_pkg::size_t size,
	output logic [31:0]        product
);
	logic        byte_form;
	logic        ext_a;
	logic        ext_b;
	logic [16:0] ax;
	logic [16:0] bx;
	logic [33:0] full;

	assign byte_form = (size == alu_pkg::sz_byte);
	assign ext_a     = is_signed & (byte_form ? a[7] : a[15]);
	assign ext_b     = is_signed & (byte_form ? b[7] : b[15]);
	assign ax        = byte_form ? {{9{ext_a}}, a[7:0]} : {ext_a, a};
	assign bx        = byte_form ? {{9{ext_b}}, b[7:0]} : {ext_b, b};
	// One sign-extended 17-bit multiply serves both signednesses
	assign full      = 34'($signed(ax) * $signed(bx));
	assign product   = full[31:0];

endmodule : mul_unit

// ==== hw/div_unit.sv ====
// Iterative restoring divider on magnitudes, one quotient bit per clock
`timescale 1ns/1ns
module div_unit (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        start,
	input  wire logic [31:0] dividend,
	input  wire logic [15:0] divisor,
	output logic             done,
	output logic [31:0]      quotient,
	output logic [15:0]      remainder
);
	logic [31:0] quo_q;
	logic [31:0] quo_d;
	logic [15:0] rem_q;
	logic [15:0] rem_d;
	logic [5:0]  cnt_q;
	logic        done_q;
	logic [16:0] trial;
	logic        fits;

	assign trial = {rem_q, quo_q[31]};
	assign fits  = (trial >= {1'b0, divisor});
	assign rem_d = fits ? 16'(trial - {1'b0, divisor}) : trial[15:0];
	assign quo_d = {quo_q[30:0], fits};

	// A zero divisor runs through and leaves an all-ones quotient
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			quo_q  <= alu_pkg::WORD_RST;
			rem_q  <= 16'h0;
			cnt_q  <= 6'h0;
			done_q <= 1'b0;
		end else begin
			done_q <= (cnt_q == 6'h1);
			if (start) begin
				quo_q <= dividend;
				rem_q <= 16'h0;
				cnt_q <= alu_pkg::DIV_STEPS;
			end else if (cnt_q != 6'h0) begin
				quo_q <= quo_d;
				rem_q <= rem_d;
				cnt_q <= cnt_q - 6'h1;
			end
		end
	end

	assign done      = done_q;
	assign quotient  = quo_q;
	assign remainder = rem_q;

	property p_div_time;
		@(posedge clk_sys) disable iff (!rst_n)
		start |-> ##33 done_q;
	endproperty
	a_div_time: assert property (p_div_time) else $error("divider done not 33 cycles after start");

endmodule : div_unit

// ==== tb/decoder_model.sv ====
// Instruction-source model: issues operations to the unit as the AHB-Lite master
`timescale 1ns/1ns
module decoder_model (
	input  wire logic        clk_sys,
	input  wire logic        hreadyout,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = alu_pkg::HSIZE_WORD;
		hwdata = 32'h0;
	end

	// Operands arrive as register values only; no immediate or register number reaches the unit
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= alu_pkg::HSIZE_WORD;
		// Stale write data is inverted so a released bus never looks valid
		hwdata <= ~hwdata;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : xfer
endmodule : decoder_model

// ==== tb/tb_cpu_arithmetic_unit.sv ====
// Self-checking bench of the arithmetic unit through its register bus
`timescale 1ns/1ns
module tb_cpu_arithmetic_unit;
	logic        clk_sys;
	logic        rst_n;
	wire         hsel;
	wire  [31:0] haddr;
	wire  [1:0]  htrans;
	wire         hwrite;
	wire  [2:0]  hsize;
	wire  [31:0] hwdata;
	wire         hreadyout;
	wire  [31:0] hrdata;
	wire         hresp;
	int          miscompares = 0;
	int          n_checks = 0;

	cpu_arithmetic_unit cpu_arithmetic_unit_inst (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
	decoder_model decoder_model_inst (.clk_sys(clk_sys), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic tally_and_finish();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish

	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : check

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		decoder_model_inst.xfer(w, a, d, q);
	endtask : bus

	// Control word is {step, size, op}; busy is polled so divide latency is not assumed
	task automatic run_op(input logic [8:0] ctl, input logic [31:0] d, input logic [31:0] s,
		input logic [3:0] fi, input logic [31:0] er, input logic [3:0] ef);
		logic [31:0] q;
		int          n;
		bus(1'b1, alu_pkg::ADDR_DST, d, q);
		bus(1'b1, alu_pkg::ADDR_SRC, s, q);
		bus(1'b1, alu_pkg::ADDR_FLAGS, {28'h0, fi}, q);
		bus(1'b1, alu_pkg::ADDR_CTRL, {23'h0, ctl}, q);
		n = 0;
		do begin
			bus(1'b0, alu_pkg::ADDR_STATUS, 32'h0, q);
			n++;
		end while (q[0] !== 1'b0 && n < 50);
		check("status", 32'h0, q);
		bus(1'b0, alu_pkg::ADDR_RESULT, 32'h0, q);
		check("result", er, q);
		bus(1'b0, alu_pkg::ADDR_FLAGS, 32'h0, q);
		check("flags", {28'h0, ef}, q);
	endtask : run_op

	task automatic t_bus();
		logic [31:0] q;
		bus(1'b0, alu_pkg::ADDR_CTRL, 32'h0, q);
		check("ctrl reset", 32'h0, q);
		bus(1'b0, alu_pkg::ADDR_FLAGS, 32'h0, q);
		check("flags reset", 32'h0, q);
		check("hresp", 32'h0, {31'h0, hresp});
		bus(1'b1, 8'h20, 32'hffffffff, q);
		bus(1'b0, 8'h20, 32'h0, q);
		check("unmapped", 32'h0, q);
		bus(1'b1, alu_pkg::ADDR_DST, 32'h00000064, q);
		bus(1'b1, alu_pkg::ADDR_SRC, 32'h00000007, q);
		bus(1'b1, alu_pkg::ADDR_CTRL, 32'h0000000c, q);
		// Write during a divide must be dropped
		bus(1'b1, alu_pkg::ADDR_DST, 32'h00000005, q);
		repeat (40) @(posedge clk_sys);
		bus(1'b0, alu_pkg::ADDR_DST, 32'h0, q);
		check("dst kept", 32'h00000064, q);
		bus(1'b0, alu_pkg::ADDR_RESULT, 32'h0, q);
		check("div result", 32'h0000020e, q);
	endtask : t_bus

	task automatic t_add_sub();
		run_op(9'h000, 32'h12345678, 32'h000000ff, 4'h0, 32'h12345677, 4'h1);
		run_op(9'h041, 32'h00000001, 32'h00000002, 4'h0, 32'hffffffff, 4'h9);
		run_op(9'h020, 32'h00007fff, 32'h00000001, 4'h0, 32'h00008000, 4'ha);
		run_op(9'h040, 32'h7fffffff, 32'h00000001, 4'h0, 32'h80000000, 4'ha);
		run_op(9'h002, 32'h00000010, 32'h00000020, 4'h1, 32'h00000031, 4'h0);
		run_op(9'h003, 32'haabb0005, 32'h00000005, 4'h4, 32'haabb0000, 4'h4);
	endtask : t_add_sub

	task automatic t_step();
		run_op(9'h0a4, 32'h0000fffe, 32'h0, 4'h0, 32'h00000000, 4'h4);
		run_op(9'h084, 32'h0000007f, 32'h0, 4'h0, 32'h00000080, 4'ha);
		run_op(9'h005, 32'h00000000, 32'h0, 4'h0, 32'h000000ff, 4'h8);
		run_op(9'h147, 32'h00000002, 32'h0, 4'h3, 32'hfffffffe, 4'h3);
		run_op(9'h146, 32'hfffffffe, 32'h0, 4'h5, 32'h00000002, 4'h5);
		run_op(9'h008, 32'h0000000f, 32'h0, 4'h0, 32'h00000015, 4'h0);
		run_op(9'h008, 32'h0000009a, 32'h0, 4'h0, 32'h00000000, 4'h5);
		run_op(9'h009, 32'h0000000f, 32'h0, 4'h0, 32'h00000009, 4'h0);
	endtask : t_step

	task automatic t_mul_div();
		run_op(9'h00a, 32'h123400ff, 32'h000000ff, 4'h0, 32'h1234fe01, 4'h0);
		run_op(9'h02a, 32'h1234ffff, 32'h0000ffff, 4'h2, 32'hfffe0001, 4'h2);
		run_op(9'h02b, 32'h0000ffff, 32'h00000002, 4'h0, 32'hfffffffe, 4'h8);
		run_op(9'h00b, 32'h000000ff, 32'h000000ff, 4'h0, 32'h00000001, 4'h0);
		run_op(9'h02c, 32'h00010000, 32'h00000003, 4'h0, 32'h00015555, 4'h0);
		run_op(9'h00d, 32'h0000fff9, 32'h00000002, 4'h0, 32'h0000fffd, 4'h8);
		run_op(9'h02d, 32'hfffffff9, 32'h00000002, 4'h0, 32'hfffffffd, 4'h8);
		run_op(9'h02c, 32'h00000005, 32'h00000000, 4'h0, 32'h0005ffff, 4'hc);
	endtask : t_mul_div

	task automatic t_misc();
		run_op(9'h04e, 32'h00000005, 32'h00000005, 4'h0, 32'h00000005, 4'h4);
		run_op(9'h00f, 32'h00000001, 32'h0, 4'h0, 32'h000000ff, 4'h9);
		run_op(9'h04f, 32'h00000001, 32'h0, 4'h0, 32'hffffffff, 4'h9);
		run_op(9'h030, 32'habcd12f0, 32'h0, 4'h0, 32'habcd00f0, 4'h0);
		run_op(9'h050, 32'habcd92f0, 32'h0, 4'h9, 32'h000092f0, 4'h1);
		run_op(9'h051, 32'h00008001, 32'h0, 4'h0, 32'hffff8001, 4'h8);
		run_op(9'h031, 32'h12340080, 32'h0, 4'h0, 32'h1234ff80, 4'h8);
		run_op(9'h012, 32'h00000000, 32'h0, 4'h0, 32'h00000080, 4'h4);
	endtask : t_misc

	initial begin
		rst_n = 1'b0;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		t_bus();
		t_add_sub();
		t_step();
		t_mul_div();
		t_misc();
		tally_and_finish();
	end

	// Whole run needs under a thousand cycles; this bound only catches a hang
	initial begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		$display("unexpected watchdog expected done seen hang");
		tally_and_finish();
	end
endmodule : tb_cpu_arithmetic_unit
